/* File: rtl/exec_pkg.sv */
// Purpose: Shared types and constants for the 8-bit execute stage.
// Assumes: One core clock, synchronous active-high reset.
// Notes: Operation codes are arbitrary internal encodings.
package exec_pkg;

    // Operand widths
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;

    // Full byte mask used to invert a clear-bits constant
    localparam logic [7:0] MASK_ALL = 8'hFF;

    // Flag reset value
    localparam logic [5:0] FLAGS_RESET = 6'h00;

    // Cycle counts per operation class
    localparam logic [1:0] CYC_SINGLE = 2'h1;
    localparam logic [1:0] CYC_DOUBLE = 2'h2;
    localparam logic [1:0] CYC_TRIPLE = 2'h3;

    // Operations handed over by the decoder
    typedef enum logic [4:0] {
        op_add = 5'h00,
        op_add_carry = 5'h01,
        op_word_plus_immediate = 5'h02,
        op_sub = 5'h03,
        op_minus_with_borrow = 5'h04,
        op_minus_constant = 5'h05,
        op_minus_constant_with_borrow = 5'h06,
        op_word_minus_immediate = 5'h07,
        op_and = 5'h08,
        op_conjunction_immediate = 5'h09,
        op_or = 5'h0A,
        op_disjunction_immediate = 5'h0B,
        op_exclusive_disjunction = 5'h0C,
        op_set_bits_in_register = 5'h0D,
        op_clear_bits_in_register = 5'h0E,
        op_test_zero_minus = 5'h0F,
        op_unsigned_product = 5'h10,
        op_signed_product = 5'h11,
        op_signed_by_unsigned_product = 5'h12,
        op_fractional_unsigned_product = 5'h13,
        op_fractional_signed_product = 5'h14,
        op_fractional_signed_by_unsigned_product = 5'h15,
        op_pointer_jump = 5'h16,
        op_pointer_subroutine_call = 5'h17
    } op_t;

    // Status flags
    typedef struct packed {
        logic polarity_bit;
        logic nibble_carry;
        logic signed_wrap_bit;
        logic msb_result_bit;
        logic all_bits_clear;
        logic borrow_out_bit;
    } flags_t;

    // One request from decoder and register file
    typedef struct packed {
        op_t op;
        logic [7:0] dest;
        logic [7:0] source_operand;
        logic [7:0] imm;
        logic [15:0] pair;
        logic [15:0] indirect_pointer_pair;
    } req_t;

    // Write-back and program-counter results
    typedef struct packed {
        logic dest_we;
        logic [7:0] dest_data;
        logic pair_we;
        logic [15:0] pair_data;
        logic product_we;
        logic [15:0] product_pair;
        logic pc_we;
        logic pc_call;
        logic [15:0] pc_data;
    } res_t;

endpackage

/* File: rtl/product_unit.sv */
// Purpose: 8x8 multiplier with signed, mixed and fractional forms.
// Assumes: Combinational; the caller registers the result.
// Notes: Carry is taken from bit 15 before the fractional shift.
`timescale 1ns/1ns
module product_unit (
    // Factors
    input wire logic [7:0] factor_a,
    input wire logic [7:0] factor_b,
    // Mode
    input wire logic signed_a,
    input wire logic signed_b,
    input wire logic fractional,
    // Product
    output logic [15:0] product,
    output logic product_carry
);
    logic signed [8:0] ext_a; // Sign or zero extended factor
    logic signed [8:0] ext_b; // Sign or zero extended factor
    logic signed [17:0] full; // Full width product
    logic [15:0] raw; // Unshifted 16-bit product

    // Extend, multiply, then optionally shift left by one
    always_comb begin
        ext_a = {signed_a & factor_a[7], factor_a};
        ext_b = {signed_b & factor_b[7], factor_b};
        full = ext_a * ext_b;
        raw = full[15:0];
        product_carry = raw[15];
        product = fractional ? {raw[14:0], 1'b0} : raw;
    end
endmodule

/* File: rtl/arith_execute.sv */
// Purpose: Execute stage: arithmetic, logic, multiply, indirect jump/call.
// Assumes: Register file reads operands; decoder waits on req_ready.
// Notes: Flags appear with the done pulse; results are registered when the request is taken.
`timescale 1ns/1ns
// Overview of operation
// - Add and add-with-carry, five flags, one cycle
// - Word plus immediate, two cycles, sign flag
// - Register subtract, with borrow variant, one cycle
// - Constant subtract, with borrow variant, one cycle
// - Word minus immediate, two cycles, sign flag
// - AND register or constant, Z N V
// - OR register/constant, XOR registers, Z N V
// - Set bits: OR with constant mask
// - Clear bits: AND with 0xFF minus constant
// - Test: AND with itself, value unchanged
// - Multiplies into product pair, Z C, two cycles
// - Fractional multiplies shift product left once
// - Pointer jump loads PC, two cycles
// - Pointer call transfers control, three cycles
module arith_execute (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Request from decoder
    input wire logic req_valid,
    input wire exec_pkg::req_t req,
    output logic req_ready,
    // Results
    output logic done,
    output exec_pkg::res_t res,
    output exec_pkg::flags_t flags
);
    // Sequencer states, Gray along idle -> wait -> last
    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_wait = 2'h1,
        st_last = 2'h3
    } state_t;

    state_t state_reg, state_next; // Sequencer
    exec_pkg::res_t res_reg, res_next; // Pending results
    exec_pkg::flags_t flags_reg, flags_next; // Live flags
    exec_pkg::flags_t pend_reg, pend_next; // Flags waiting for done
    logic done_reg, done_next; // Completion pulse

    logic accept; // Request taken this edge
    logic [15:0] mul_product; // Multiplier output
    logic mul_carry; // Multiplier carry
    logic mul_sa, mul_sb, mul_frac; // Multiplier mode

    // Multiplier modes from the operation code
    always_comb begin
        mul_sa = req.op inside {exec_pkg::op_signed_product, exec_pkg::op_signed_by_unsigned_product,
            exec_pkg::op_fractional_signed_product, exec_pkg::op_fractional_signed_by_unsigned_product};
        mul_sb = req.op inside {exec_pkg::op_signed_product, exec_pkg::op_fractional_signed_product};
        mul_frac = req.op inside {exec_pkg::op_fractional_unsigned_product,
            exec_pkg::op_fractional_signed_product, exec_pkg::op_fractional_signed_by_unsigned_product};
    end

    // Shared multiplier
    product_unit u_mul (
        .factor_a(req.dest),
        .factor_b(req.source_operand),
        .signed_a(mul_sa),
        .signed_b(mul_sb),
        .fractional(mul_frac),
        .product(mul_product),
        .product_carry(mul_carry)
    );

    assign req_ready = (state_reg == st_idle);
    assign accept = req_valid && req_ready;
    assign done = done_reg;
    assign res = res_reg;
    assign flags = flags_reg;

    // Next-state computation for the whole stage
    always_comb begin
        logic [7:0] a, b, r;
        logic cin, is_sub;
        logic [8:0] wide;
        logic [4:0] nib;
        logic [16:0] wsum;
        logic [1:0] cycles;
        a = req.dest;
        b = req.source_operand;
        r = 8'h00;
        cin = 1'b0;
        is_sub = 1'b0;
        wide = 9'h000;
        nib = 5'h00;
        wsum = 17'h0_0000;
        cycles = exec_pkg::CYC_SINGLE;
        state_next = state_reg;
        res_next = res_reg;
        flags_next = flags_reg;
        pend_next = pend_reg;
        done_next = 1'b0;

        // Finish multi-cycle work
        case (state_reg)
            st_idle: begin
            end
            st_wait: begin
                state_next = st_last;
            end
            st_last: begin
                state_next = st_idle;
                done_next = 1'b1;
                flags_next = pend_reg;
            end
            default: begin
                state_next = st_idle;
            end
        endcase

        if (accept) begin
            // Untouched flags carry over
            pend_next = flags_reg;
            res_next = '0;
            case (req.op)
                exec_pkg::op_add, exec_pkg::op_add_carry: begin
                    cin = (req.op == exec_pkg::op_add_carry) && flags_reg.borrow_out_bit;
                    wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                end
                exec_pkg::op_sub, exec_pkg::op_minus_with_borrow, exec_pkg::op_minus_constant,
                exec_pkg::op_minus_constant_with_borrow: begin
                    is_sub = 1'b1;
                    if (req.op inside {exec_pkg::op_minus_constant, exec_pkg::op_minus_constant_with_borrow}) begin
                        b = req.imm;
                    end
                    cin = (req.op inside {exec_pkg::op_minus_with_borrow, exec_pkg::op_minus_constant_with_borrow})
                        && flags_reg.borrow_out_bit;
                    // Top bit set when b plus borrow exceeds a
                    wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                    nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
                end
                default: begin
                end
            endcase

            // Byte add or subtract write-back and five flags
            if (req.op inside {exec_pkg::op_add, exec_pkg::op_add_carry, exec_pkg::op_sub,
                exec_pkg::op_minus_with_borrow, exec_pkg::op_minus_constant,
                exec_pkg::op_minus_constant_with_borrow}) begin
                r = wide[7:0];
                res_next.dest_we = 1'b1;
                res_next.dest_data = r;
                pend_next.borrow_out_bit = wide[8];
                pend_next.nibble_carry = nib[4];
                pend_next.all_bits_clear = (r == 8'h00);
                pend_next.msb_result_bit = r[7];
                pend_next.signed_wrap_bit = is_sub ? ((a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]))
                    : ((a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]));
            end

            // Logic operations, Z N V only
            if (req.op inside {exec_pkg::op_and, exec_pkg::op_conjunction_immediate, exec_pkg::op_or,
                exec_pkg::op_disjunction_immediate, exec_pkg::op_exclusive_disjunction,
                exec_pkg::op_set_bits_in_register, exec_pkg::op_clear_bits_in_register,
                exec_pkg::op_test_zero_minus}) begin
                case (req.op)
                    exec_pkg::op_and: r = a & b;
                    exec_pkg::op_conjunction_immediate: r = a & req.imm;
                    exec_pkg::op_or: r = a | b;
                    exec_pkg::op_disjunction_immediate: r = a | req.imm;
                    exec_pkg::op_exclusive_disjunction: r = a ^ b;
                    exec_pkg::op_set_bits_in_register: r = a | req.imm;
                    exec_pkg::op_clear_bits_in_register: r = a & (exec_pkg::MASK_ALL - req.imm);
                    default: r = a & a;
                endcase
                res_next.dest_we = 1'b1;
                res_next.dest_data = r;
                pend_next.all_bits_clear = (r == 8'h00);
                pend_next.msb_result_bit = r[7];
                pend_next.signed_wrap_bit = 1'b0;
            end

            // Word add or subtract of an immediate
            if (req.op inside {exec_pkg::op_word_plus_immediate, exec_pkg::op_word_minus_immediate}) begin
                cycles = exec_pkg::CYC_DOUBLE;
                if (req.op == exec_pkg::op_word_plus_immediate) begin
                    wsum = {1'b0, req.pair} + {9'h000, req.imm};
                    pend_next.signed_wrap_bit = ~req.pair[15] & wsum[15];
                end else begin
                    wsum = {1'b0, req.pair} - {9'h000, req.imm};
                    pend_next.signed_wrap_bit = req.pair[15] & ~wsum[15];
                end
                res_next.pair_we = 1'b1;
                res_next.pair_data = wsum[15:0];
                pend_next.borrow_out_bit = wsum[16];
                pend_next.all_bits_clear = (wsum[15:0] == 16'h0000);
                pend_next.msb_result_bit = wsum[15];
                pend_next.polarity_bit = wsum[15] ^ pend_next.signed_wrap_bit;
            end

            // Multiplies into the product pair
            if (req.op inside {[exec_pkg::op_unsigned_product :
                exec_pkg::op_fractional_signed_by_unsigned_product]}) begin
                cycles = exec_pkg::CYC_DOUBLE;
                res_next.product_we = 1'b1;
                res_next.product_pair = mul_product;
                pend_next.borrow_out_bit = mul_carry;
                pend_next.all_bits_clear = (mul_product == 16'h0000);
            end

            // Indirect jump and call, no flags
            if (req.op inside {exec_pkg::op_pointer_jump, exec_pkg::op_pointer_subroutine_call}) begin
                res_next.pc_we = 1'b1;
                res_next.pc_data = req.indirect_pointer_pair;
                res_next.pc_call = (req.op == exec_pkg::op_pointer_subroutine_call);
                cycles = res_next.pc_call ? exec_pkg::CYC_TRIPLE : exec_pkg::CYC_DOUBLE;
            end

            // Schedule completion by cycle count
            case (cycles)
                exec_pkg::CYC_DOUBLE: state_next = st_last;
                exec_pkg::CYC_TRIPLE: state_next = st_wait;
                default: begin
                    done_next = 1'b1;
                    flags_next = pend_next;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= st_idle;
            res_reg <= '0;
            flags_reg <= exec_pkg::FLAGS_RESET;
            pend_reg <= exec_pkg::FLAGS_RESET;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            res_reg <= res_next;
            flags_reg <= flags_next;
            pend_reg <= pend_next;
            done_reg <= done_next;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_taken(exec_pkg::op_t o);
        req_valid && req_ready && req.op == o;
    endsequence

    add_result_a: assert property (s_taken(exec_pkg::op_add) |=> done && res.dest_data ==
        8'($past(req.dest) + $past(req.source_operand)))
        else $error("add result or timing wrong");
    word_timing_a: assert property (s_taken(exec_pkg::op_word_plus_immediate) |=> !done ##1
        (done && res.pair_data == 16'($past(req.pair, 2) + {8'h00, $past(req.imm, 2)})))
        else $error("word add wrong");
    sub_borrow_a: assert property (s_taken(exec_pkg::op_sub) |=> flags.borrow_out_bit ==
        ($past(req.source_operand) > $past(req.dest)))
        else $error("subtract borrow wrong");
    logic_flags_a: assert property (s_taken(exec_pkg::op_and) |=> !flags.signed_wrap_bit &&
        flags.borrow_out_bit == $past(flags.borrow_out_bit) && flags.polarity_bit == $past(flags.polarity_bit))
        else $error("logic flags wrong");
    clear_bits_a: assert property (s_taken(exec_pkg::op_clear_bits_in_register) |=>
        res.dest_data == ($past(req.dest) & ~$past(req.imm)))
        else $error("clear bits wrong");
    mul_product_a: assert property (s_taken(exec_pkg::op_unsigned_product) |=> !done ##1 (done &&
        res.product_pair == ({8'h00, $past(req.dest, 2)} * {8'h00, $past(req.source_operand, 2)})))
        else $error("product wrong");
    jump_pc_a: assert property (s_taken(exec_pkg::op_pointer_jump) |=> !done ##1 (done && res.pc_we &&
        res.pc_data == $past(req.indirect_pointer_pair, 2) && flags == $past(flags, 2)))
        else $error("jump wrong");
    call_timing_a: assert property (s_taken(exec_pkg::op_pointer_subroutine_call) |=>
        (!done && !req_ready) [*2] ##1 (done && res.pc_call))
        else $error("call timing wrong");
endmodule

/* File: bench/exec_feeder.sv */
// Purpose: Decoder and register-file model that feeds the execute stage.
// Assumes: Requests change at the falling edge of clk.
// Notes: Request fields are scrambled after each request is released.
`timescale 1ns/1ns
module exec_feeder (
    // Clock
    input wire logic clk,
    // Answers from the block
    input wire logic req_ready,
    input wire logic done,
    // Request to the block
    output logic req_valid,
    output exec_pkg::req_t req
);
    // Idle at time zero
    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // Offer one request after gap idle cycles, then time the answer
    task automatic issue(input exec_pkg::req_t r, input int gap, output int cyc, output logic rdy);
        int n;
        repeat (gap + 1) @(negedge clk);
        req_valid = 1'b1;
        req = r;
        n = 0;
        // Ready seen at the falling edge still holds at the next rising edge
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        @(negedge clk);
        // Release, and scramble the fields so stale values cannot pass
        req_valid = 1'b0;
        req = ~r;
        rdy = req_ready;
        cyc = 1;
        // Bounded wait for the done pulse
        while (done !== 1'b1 && cyc < 10) begin
            @(negedge clk);
            cyc++;
        end
        if (done !== 1'b1) begin
            cyc = -1;
        end
    endtask
endmodule

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the execute stage.
// Assumes: 100 MHz clock, reset held for four cycles.
// Notes: Expected flags are tracked here, starting from the reset value.
`timescale 1ns/1ns
module tb_top;
    // Clock, reset and block signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid;
    logic req_ready;
    logic done;
    exec_pkg::req_t req;
    exec_pkg::res_t res;
    exec_pkg::flags_t flags;
    exec_pkg::flags_t ef; // Expected flags
    int miscompares = 0;
    int n_checks = 0;

    // Clock generator
    always #5 clk = ~clk;

    arith_execute i_dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .res(res), .flags(flags));
    exec_feeder i_feed (.clk(clk), .req_ready(req_ready), .done(done), .req_valid(req_valid), .req(req));

    // Value comparison
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Flag comparison
    task automatic cmp_flags(input exec_pkg::flags_t got, input exec_pkg::flags_t exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t flags got %b exp %b", $time, got, exp);
        end
    endtask

    // Run one operation and judge cycles, write-back and flags
    task automatic run_op(input exec_pkg::op_t op, input logic [7:0] d, input logic [7:0] s,
        input logic [15:0] p, input int gap);
        exec_pkg::req_t r;
        logic [8:0] w9;
        logic [16:0] w17;
        logic [15:0] pa;
        logic [15:0] pb;
        logic [15:0] v;
        logic [15:0] got;
        logic [4:0] we;
        logic [1:0] ncyc;
        logic cin;
        logic rdy;
        int cyc;
        r = '{op: op, dest: d, source_operand: s, imm: s, pair: p, indirect_pointer_pair: p};
        cin = ef.borrow_out_bit;
        ncyc = exec_pkg::CYC_SINGLE;
        we = 5'h10;
        case (op)
            // Byte add
            exec_pkg::op_add, exec_pkg::op_add_carry: begin
                cin = (op == exec_pkg::op_add) ? 1'b0 : cin;
                w9 = {1'b0, d} + {1'b0, s} + {8'h00, cin};
                v = {8'h00, w9[7:0]};
                ef.borrow_out_bit = w9[8];
                ef.nibble_carry = ({1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cin}) > 5'h0F;
                ef.signed_wrap_bit = (d[7] == s[7]) && (w9[7] != d[7]);
            end
            // Byte subtract
            exec_pkg::op_sub, exec_pkg::op_minus_with_borrow, exec_pkg::op_minus_constant,
            exec_pkg::op_minus_constant_with_borrow: begin
                if (op == exec_pkg::op_sub || op == exec_pkg::op_minus_constant) begin
                    cin = 1'b0;
                end
                w9 = {1'b0, d} - {1'b0, s} - {8'h00, cin};
                v = {8'h00, w9[7:0]};
                ef.borrow_out_bit = ({1'b0, s} + {8'h00, cin}) > {1'b0, d};
                ef.nibble_carry = ({1'b0, s[3:0]} + {4'h0, cin}) > {1'b0, d[3:0]};
                ef.signed_wrap_bit = (d[7] != s[7]) && (w9[7] != d[7]);
            end
            // Word add and subtract on the pair
            exec_pkg::op_word_plus_immediate, exec_pkg::op_word_minus_immediate: begin
                ncyc = exec_pkg::CYC_DOUBLE;
                we = 5'h08;
                if (op == exec_pkg::op_word_plus_immediate) begin
                    w17 = {1'b0, p} + {9'h000, s};
                    ef.signed_wrap_bit = ~p[15] & w17[15];
                end else begin
                    w17 = {1'b0, p} - {9'h000, s};
                    ef.signed_wrap_bit = p[15] & ~w17[15];
                end
                v = w17[15:0];
                ef.borrow_out_bit = w17[16];
            end
            // Multiplies, plain and fractional
            exec_pkg::op_unsigned_product, exec_pkg::op_signed_product,
            exec_pkg::op_signed_by_unsigned_product, exec_pkg::op_fractional_unsigned_product,
            exec_pkg::op_fractional_signed_product, exec_pkg::op_fractional_signed_by_unsigned_product: begin
                ncyc = exec_pkg::CYC_DOUBLE;
                we = 5'h04;
                pa = (op inside {exec_pkg::op_unsigned_product, exec_pkg::op_fractional_unsigned_product})
                    ? {8'h00, d} : {{8{d[7]}}, d};
                pb = (op inside {exec_pkg::op_signed_product, exec_pkg::op_fractional_signed_product})
                    ? {{8{s[7]}}, s} : {8'h00, s};
                v = pa * pb;
                ef.borrow_out_bit = v[15];
                if (op >= exec_pkg::op_fractional_unsigned_product) begin
                    v = v << 1;
                end
            end
            // Indirect jump and call
            exec_pkg::op_pointer_jump, exec_pkg::op_pointer_subroutine_call: begin
                ncyc = (op == exec_pkg::op_pointer_jump) ? exec_pkg::CYC_DOUBLE : exec_pkg::CYC_TRIPLE;
                we = (op == exec_pkg::op_pointer_jump) ? 5'h02 : 5'h03;
                v = p;
            end
            // Logic operations
            default: begin
                case (op)
                    exec_pkg::op_and, exec_pkg::op_conjunction_immediate: v = {8'h00, d & s};
                    exec_pkg::op_exclusive_disjunction: v = {8'h00, d ^ s};
                    exec_pkg::op_clear_bits_in_register: v = {8'h00, d & (8'hFF - s)};
                    exec_pkg::op_test_zero_minus: v = {8'h00, d & d};
                    default: v = {8'h00, d | s};
                endcase
                ef.signed_wrap_bit = 1'b0;
            end
        endcase
        // Zero, sign and polarity by result class
        if (we[4]) begin
            ef.all_bits_clear = v[7:0] == 8'h00;
            ef.msb_result_bit = v[7];
        end
        if (we[3]) begin
            ef.all_bits_clear = v == 16'h0000;
            ef.msb_result_bit = v[15];
            ef.polarity_bit = v[15] ^ ef.signed_wrap_bit;
        end
        if (we[2]) begin
            ef.all_bits_clear = v == 16'h0000;
        end
        i_feed.issue(r, gap, cyc, rdy);
        got = we[4] ? {8'h00, res.dest_data} : we[3] ? res.pair_data : we[2] ? res.product_pair : res.pc_data;
        cmp_val(16'(cyc), {14'h0, ncyc}, "cycles");
        cmp_val({15'h0, rdy}, {15'h0, ncyc == exec_pkg::CYC_SINGLE}, "ready after take");
        cmp_val({11'h0, res.dest_we, res.pair_we, res.product_we, res.pc_we, res.pc_call},
            {11'h0, we}, "enables");
        cmp_val(got, v, "result");
        cmp_flags(flags, ef);
    endtask

    // Idle state after reset
    task automatic t_reset();
        cmp_val({14'h0, req_ready, done}, 16'h0002, "reset handshake");
        cmp_flags(flags, exec_pkg::FLAGS_RESET);
        $display("test reset finished");
    endtask

    // Adds at carry, nibble and overflow boundaries
    task automatic t_add();
        run_op(exec_pkg::op_add, 8'h0F, 8'h01, 16'h0000, 0);
        run_op(exec_pkg::op_add, 8'hFF, 8'h01, 16'h0000, 0);
        run_op(exec_pkg::op_add_carry, 8'h7F, 8'h00, 16'h0000, 2);
        run_op(exec_pkg::op_add, 8'h80, 8'h80, 16'h0000, 0);
        $display("test add finished");
    endtask

    // Subtracts with and without incoming borrow
    task automatic t_sub();
        run_op(exec_pkg::op_sub, 8'h00, 8'h01, 16'h0000, 0);
        run_op(exec_pkg::op_minus_with_borrow, 8'h10, 8'h0F, 16'h0000, 0);
        run_op(exec_pkg::op_minus_constant, 8'h80, 8'h01, 16'h0000, 0);
        run_op(exec_pkg::op_minus_constant_with_borrow, 8'h05, 8'h05, 16'h0000, 0);
        run_op(exec_pkg::op_sub, 8'h20, 8'h21, 16'h0000, 0);
        $display("test sub finished");
    endtask

    // Logic operations, borrow left set beforehand
    task automatic t_logic();
        exec_pkg::op_t ops[8] = '{exec_pkg::op_and, exec_pkg::op_conjunction_immediate, exec_pkg::op_or,
            exec_pkg::op_disjunction_immediate, exec_pkg::op_exclusive_disjunction,
            exec_pkg::op_set_bits_in_register, exec_pkg::op_clear_bits_in_register, exec_pkg::op_test_zero_minus};
        foreach (ops[i]) begin
            run_op(ops[i], 8'hA5, 8'h5A, 16'h0000, 0);
            run_op(ops[i], 8'hC3, 8'hC3, 16'h0000, 1);
        end
        $display("test logic finished");
    endtask

    // Word operations over wrap and sign boundaries
    task automatic t_word();
        run_op(exec_pkg::op_word_plus_immediate, 8'h00, 8'h01, 16'hFFFF, 0);
        run_op(exec_pkg::op_word_plus_immediate, 8'h00, 8'h3F, 16'h7FF0, 3);
        run_op(exec_pkg::op_word_minus_immediate, 8'h00, 8'h01, 16'h0000, 0);
        run_op(exec_pkg::op_word_minus_immediate, 8'h00, 8'h01, 16'h8000, 0);
        $display("test word finished");
    endtask

    // All six multiplies with signed corner factors and a zero product
    task automatic t_mul();
        for (int k = 16; k < 22; k++) begin
            run_op(exec_pkg::op_t'(k), 8'h80, 8'hFF, 16'h0000, 0);
            run_op(exec_pkg::op_t'(k), 8'hC0, 8'h40, 16'h0000, 0);
            run_op(exec_pkg::op_t'(k), 8'h00, 8'h9B, 16'h0000, 1);
        end
        $display("test mul finished");
    endtask

    // Indirect jump and call
    task automatic t_ptr();
        run_op(exec_pkg::op_pointer_jump, 8'h00, 8'h00, 16'h1234, 0);
        run_op(exec_pkg::op_pointer_subroutine_call, 8'h00, 8'h00, 16'hBEEF, 0);
        run_op(exec_pkg::op_pointer_jump, 8'h00, 8'h00, 16'h0000, 2);
        $display("test pointer finished");
    endtask

    // Counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        ef = exec_pkg::FLAGS_RESET;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_add();
        t_sub();
        t_logic();
        t_word();
        t_mul();
        t_ptr();
        stop_test();
    end

    // Watchdog, well beyond the 150 or so cycles the tests need
    initial begin
        #50000;
        miscompares++;
        stop_test();
    end
endmodule
